// ---- src/uhc_cmd_ctrl.v ----
// Command-register control for a high-speed USB host controller: run/stop,
// soft reset, schedule enables, doorbell, and stop on failed memory reads.
// Assumes an AXI4-Lite master on aclk and a schedule engine on the same clock.
//
// Functional notes
// - Async enable bit5 reset 0 skips async schedule; 1 fetches via async pointer.
// - Periodic enable bit4 reset 0 skips periodic schedule; 1 fetches via periodic pointer.
// - Frame list size bits 3:2 read-only zero; only 1024 entries supported.
// - Soft reset bit1 resets pipelines, timers, state; aborts transfer; no bus reset.
// - Soft reset restores operational registers, ports; ownership to companion controllers.
// - Hardware clears soft reset bit when done; writing 0 cannot cut it short.
// - Soft reset leaves configuration and capability registers unchanged.
// - Run/stop bit0 resets to 0; while 1 schedules keep executing.
// - Clearing run finishes current transaction, then stops and sets stopped flag.
// - Stopped flag clears at once when run is set.
// - Run/stopped pairs: 00 halting, 01 halted, 10 running.
// - Failed memory read clears run/stop, stopping schedule execution.
// - Stopped flag reset 1; set after stop from software or error.
// - Schedule status bits report real enable state, lagging the enables.
// - After eviction following doorbell, set advance flag then clear doorbell.
`timescale 1ns/1ps
`include "uhc_consts.vh"

module uhc_cmd_ctrl #(
  parameter CAP_WORD = 32'h0000_0001   // Capability word; value is arbitrary
) (
  input  wire        aclk,            // Core clock
  input  wire        aresetn,         // Synchronous reset, active low
  input  wire [7:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output wire        s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output wire        s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [7:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output wire        s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  input  wire        xact_busy,       // Engine has a transaction on the bus
  input  wire        mem_rd_done,     // Memory read completed, pulse
  input  wire        mem_rd_ok,       // Completion status was successful
  output reg         sched_run,       // Engine may execute schedules
  output reg         async_active,    // Async schedule fetch enabled
  output reg         periodic_active, // Periodic schedule fetch enabled
  output reg  [31:0] async_fetch_ptr, // Pointer used for async fetches
  output reg  [31:0] periodic_fetch_ptr, // Pointer used for periodic fetches
  output reg         xact_abort,      // Abort transaction in progress
  output reg         port_reset,      // Return port logic to initial state
  output reg         port_to_companion, // Hand port ownership to companions
  output reg         cache_evict      // Evict cached async state
);

  // ==========================================================================
  // Controller state
  localparam ST_STOPPED = 4'b0001;
  localparam ST_RUNNING = 4'b0010;
  localparam ST_HALTING = 4'b0100;
  localparam ST_RESET   = 4'b1000;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg        run_reg;
  reg        srst_reg;
  reg        ase_reg;
  reg        pse_reg;
  reg        bell_reg;
  reg        stopped_reg;
  reg        adv_reg;
  reg        ass_reg;
  reg        pss_reg;
  reg [31:0] async_ptr_reg;
  reg [31:0] per_ptr_reg;
  reg [7:0]  srst_cnt_reg;
  reg [3:0]  lag_cnt_reg;
  reg [3:0]  evict_cnt_reg;
  reg        evict_reg;

  // ==========================================================================
  // Bus write channel: address and data may be accepted in separate cycles
  reg        aw_held_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

  wire        aw_now   = aw_held_reg | s_axi_awvalid;
  wire        w_now    = w_held_reg | s_axi_wvalid;
  wire        wr_fire  = aw_now & w_now & ~s_axi_bvalid;
  wire [7:0]  wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire        wr_cmd   = wr_fire & (wr_addr == `UHC_CMD_OFF) & wr_strb[0];
  wire        wr_sts   = wr_fire & (wr_addr == `UHC_STS_OFF) & wr_strb[0];
  wire        wr_mapped = (wr_addr == `UHC_CMD_OFF) | (wr_addr == `UHC_STS_OFF) |
                          (wr_addr == `UHC_ASYNC_PTR_OFF) | (wr_addr == `UHC_PER_PTR_OFF);

  // Byte-lane merge for the pointer registers
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  // Software may set run only while stopped; the run write clears stopped at once
  wire run_set  = wr_cmd & wr_data[`UHC_CMD_RUN] & ~run_reg;
  wire run_clr  = wr_cmd & ~wr_data[`UHC_CMD_RUN];
  wire rd_fail  = mem_rd_done & ~mem_rd_ok;
  wire srst_set = wr_cmd & wr_data[`UHC_CMD_SRST] & ~srst_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UHC_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `UHC_RESP_OKAY : `UHC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Run/stop sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_STOPPED: begin
        if (srst_set)
          state_next = ST_RESET;
        else if (run_set)
          state_next = ST_RUNNING;
      end
      ST_RUNNING: begin
        if (run_clr | rd_fail)
          state_next = ST_HALTING;
      end
      ST_HALTING: begin
        // The engine sees run drop one cycle late and could start one more transfer
        if (!xact_busy && !sched_run)
          state_next = ST_STOPPED;
      end
      ST_RESET: begin
        if (srst_cnt_reg == 8'h01)
          state_next = ST_STOPPED;
      end
      default: state_next = ST_STOPPED;
    endcase
  end

  // ==========================================================================
  // Operational registers; soft reset restores them but not the capability word
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_STOPPED;
      run_reg       <= 1'b0;
      srst_reg      <= 1'b0;
      ase_reg       <= 1'b0;
      pse_reg       <= 1'b0;
      bell_reg      <= 1'b0;
      stopped_reg   <= 1'b1;
      adv_reg       <= 1'b0;
      ass_reg       <= 1'b0;
      pss_reg       <= 1'b0;
      async_ptr_reg <= 32'h0000_0000;
      per_ptr_reg   <= 32'h0000_0000;
      srst_cnt_reg  <= 8'h00;
      lag_cnt_reg   <= 4'h0;
      evict_cnt_reg <= 4'h0;
      evict_reg     <= 1'b0;
    end else if (state_reg == ST_RESET) begin
      // Writes during reset are dropped; the bit cannot be cut short
      state_reg     <= state_next;
      srst_cnt_reg  <= srst_cnt_reg - 8'h01;
      srst_reg      <= (state_next == ST_RESET);
      run_reg       <= 1'b0;
      ase_reg       <= 1'b0;
      pse_reg       <= 1'b0;
      bell_reg      <= 1'b0;
      stopped_reg   <= 1'b1;
      adv_reg       <= 1'b0;
      ass_reg       <= 1'b0;
      pss_reg       <= 1'b0;
      async_ptr_reg <= 32'h0000_0000;
      per_ptr_reg   <= 32'h0000_0000;
      lag_cnt_reg   <= 4'h0;
      evict_cnt_reg <= 4'h0;
      evict_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (srst_set && state_reg == ST_STOPPED) begin
        srst_reg     <= 1'b1;
        srst_cnt_reg <= `UHC_SRST_CYCLES;
      end
      // Run bit: error clear outranks a simultaneous software set
      if (rd_fail && run_reg)
        run_reg <= 1'b0;
      else if (wr_cmd && state_reg != ST_HALTING)
        run_reg <= wr_data[`UHC_CMD_RUN] & ~(srst_set & (state_reg == ST_STOPPED));
      if (state_next == ST_RUNNING && state_reg == ST_STOPPED)
        stopped_reg <= 1'b0;
      else if (state_next == ST_STOPPED && state_reg == ST_HALTING)
        stopped_reg <= 1'b1;
      if (wr_cmd) begin
        ase_reg <= wr_data[`UHC_CMD_ASE];
        pse_reg <= wr_data[`UHC_CMD_PSE];
      end
      if (wr_fire && wr_addr == `UHC_ASYNC_PTR_OFF)
        async_ptr_reg <= merge(async_ptr_reg, wr_data, wr_strb);
      if (wr_fire && wr_addr == `UHC_PER_PTR_OFF)
        per_ptr_reg <= merge(per_ptr_reg, wr_data, wr_strb);
      // Status follows enables only after a settling lag
      if ((ass_reg != ase_reg) || (pss_reg != pse_reg)) begin
        if (lag_cnt_reg == `UHC_SCHED_LAG) begin
          ass_reg     <= ase_reg;
          pss_reg     <= pse_reg;
          lag_cnt_reg <= 4'h0;
        end else begin
          lag_cnt_reg <= lag_cnt_reg + 4'h1;
        end
      end else begin
        lag_cnt_reg <= 4'h0;
      end
      // Doorbell: evict, then set advance flag, then drop the bell
      if (wr_cmd && wr_data[`UHC_CMD_DOORBELL] && !bell_reg) begin
        bell_reg      <= 1'b1;
        evict_reg     <= 1'b1;
        evict_cnt_reg <= `UHC_EVICT_CYCLES;
      end else if (evict_reg) begin
        if (evict_cnt_reg == 4'h1)
          evict_reg <= 1'b0;
        evict_cnt_reg <= evict_cnt_reg - 4'h1;
      end else if (bell_reg && adv_reg) begin
        bell_reg <= 1'b0;
      end
      // Set wins over a same-cycle write-one-to-clear
      if (evict_reg && evict_cnt_reg == 4'h1)
        adv_reg <= 1'b1;
      else if (wr_sts && wr_data[`UHC_STS_ADV])
        adv_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Engine-facing outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      sched_run          <= 1'b0;
      async_active       <= 1'b0;
      periodic_active    <= 1'b0;
      async_fetch_ptr    <= 32'h0000_0000;
      periodic_fetch_ptr <= 32'h0000_0000;
      xact_abort         <= 1'b0;
      port_reset         <= 1'b0;
      port_to_companion  <= 1'b0;
      cache_evict        <= 1'b0;
    end else begin
      sched_run          <= (state_reg == ST_RUNNING);
      async_active       <= (state_reg == ST_RUNNING) & ass_reg;
      periodic_active    <= (state_reg == ST_RUNNING) & pss_reg;
      async_fetch_ptr    <= async_ptr_reg;
      periodic_fetch_ptr <= per_ptr_reg;
      // No downstream bus reset is driven; only internal logic is reset
      xact_abort         <= (state_reg == ST_RESET);
      port_reset         <= (state_reg == ST_RESET);
      port_to_companion  <= (state_reg == ST_RESET);
      cache_evict        <= evict_reg;
    end
  end

  // ==========================================================================
  // Bus read channel
  wire [31:0] cmd_view = {25'h0, bell_reg, ase_reg, pse_reg, `UHC_FLS_VALUE, srst_reg, run_reg};
  wire [31:0] sts_view = {16'h0, ass_reg, pss_reg, 1'b0, stopped_reg, 6'h0, adv_reg, 5'h0};

  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `UHC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `UHC_RESP_OKAY;
      case (s_axi_araddr)
        `UHC_CMD_OFF:       s_axi_rdata <= cmd_view;
        `UHC_STS_OFF:       s_axi_rdata <= sts_view;
        `UHC_ASYNC_PTR_OFF: s_axi_rdata <= async_ptr_reg;
        `UHC_PER_PTR_OFF:   s_axi_rdata <= per_ptr_reg;
        `UHC_ENG_OFF:       s_axi_rdata <= CAP_WORD;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `UHC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // uhc_cmd_ctrl

// ---- src/uhc_consts.vh ----
// Offsets, field positions and timing counts for the command-control block.
// Included by the block's design file and by its testbench; definitions only.
`ifndef UHC_CONSTS_VH
`define UHC_CONSTS_VH

// Register byte offsets
`define UHC_CMD_OFF        8'h00
`define UHC_STS_OFF        8'h04
`define UHC_ASYNC_PTR_OFF  8'h08
`define UHC_PER_PTR_OFF    8'h0c
`define UHC_ENG_OFF        8'h10

// Command register fields
`define UHC_CMD_RUN        0
`define UHC_CMD_SRST       1
`define UHC_CMD_FLS_LO     2
`define UHC_CMD_FLS_HI     3
`define UHC_CMD_PSE        4
`define UHC_CMD_ASE        5
`define UHC_CMD_DOORBELL   6

// Status register fields
`define UHC_STS_ADV        5
`define UHC_STS_STOPPED    12
`define UHC_STS_PSS        14
`define UHC_STS_ASS        15

// Reset values
`define UHC_CMD_RESET      32'h0000_0000
`define UHC_STS_RESET      32'h0000_1000
`define UHC_FLS_VALUE      2'h0

// Timing counts in core clock cycles
`define UHC_SRST_CYCLES    8'h10
`define UHC_SCHED_LAG      4'h4
`define UHC_EVICT_CYCLES   4'h3

// Bus responses
`define UHC_RESP_OKAY      2'h0
`define UHC_RESP_SLVERR    2'h2

`endif

// ---- verif/uhc_mem_model.sv ----
// Schedule engine and host memory standing behind the command-control block.
// Assumes the core clock and synchronous reset of the block it faces.
`timescale 1ns/1ps
module uhc_mem_model (
  input  wire  aclk,        // Core clock
  input  wire  aresetn,     // Synchronous reset, active low
  input  wire  sched_run,   // Block lets schedules execute
  input  wire  hold_busy,   // Bench stretches the current transaction
  input  wire  fail_next,   // Bench makes completions unsuccessful
  output logic xact_busy,   // Transaction in flight
  output logic mem_rd_done, // Read completion pulse
  output logic mem_rd_ok    // Completion status
);
  logic [1:0] cnt_reg;      // Cycles spent in the current transaction

  // ==========================================================
  // One four-cycle read per transaction while running
  always @(posedge aclk) begin
    mem_rd_done <= 1'b0;
    mem_rd_ok   <= ~mem_rd_ok;  // Status is meaningless outside a completion
    if (!aresetn) begin
      cnt_reg   <= 2'h0;
      xact_busy <= 1'b0;
      mem_rd_ok <= 1'b0;
    end else if (xact_busy) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == 2'h3 && !hold_busy) begin
        xact_busy   <= 1'b0;
        mem_rd_done <= 1'b1;
        mem_rd_ok   <= !fail_next;
      end
    end else if (sched_run) begin
      xact_busy <= 1'b1;
      cnt_reg   <= 2'h0;
    end
  end
endmodule // uhc_mem_model

// ---- verif/uhc_cmd_ctrl_properties.sv ----
// Concurrent checks on the command-control block, seen from its ports.
// Assumes it is bound into every instance of the block.
`timescale 1ns/1ps
module uhc_cmd_ctrl_properties (
  input wire        aclk,               // Core clock
  input wire        aresetn,            // Synchronous reset, active low
  input wire        s_axi_awready,      // Write address ready
  input wire [1:0]  s_axi_bresp,        // Write response
  input wire        s_axi_bvalid,       // Write response valid
  input wire        s_axi_bready,       // Write response ready
  input wire        s_axi_arready,      // Read address ready
  input wire [31:0] s_axi_rdata,        // Read data
  input wire        s_axi_rvalid,       // Read data valid
  input wire        s_axi_rready,       // Read data ready
  input wire        mem_rd_done,        // Memory read completed
  input wire        mem_rd_ok,          // Completion status
  input wire        sched_run,          // Schedules may execute
  input wire        async_active,       // Async fetch enabled
  input wire        periodic_active,    // Periodic fetch enabled
  input wire [31:0] async_fetch_ptr,    // Async pointer copy
  input wire [31:0] periodic_fetch_ptr, // Periodic pointer copy
  input wire        xact_abort,         // Abort in progress
  input wire        port_reset,         // Port logic reset
  input wire        port_to_companion,  // Ownership handed over
  input wire        cache_evict         // Eviction window
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Register bus
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while a response waits");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data waits");

  // ==========================================================
  // Run control, soft reset and doorbell eviction
  a_stop_on_err: assert property (sched_run && mem_rd_done && !mem_rd_ok |-> ##[1:3] !sched_run)
    else $error("failed read did not stop execution");
  a_sched_needs_run: assert property (async_active || periodic_active |-> sched_run || $past(sched_run))
    else $error("schedule fetch enabled while not running");
  a_srst_lines: assert property (xact_abort == port_reset && port_to_companion == port_reset)
    else $error("soft reset outputs disagree");
  a_srst_length: assert property ($rose(port_reset) |-> port_reset [*8] ##1 port_reset [*8] ##1 !port_reset)
    else $error("soft reset did not last sixteen cycles");
  a_srst_quiet: assert property (port_reset |-> !sched_run && !async_active && !periodic_active)
    else $error("execution during soft reset");
  a_srst_clears: assert property ($fell(port_reset) |-> async_fetch_ptr == 32'h0 && periodic_fetch_ptr == 32'h0)
    else $error("pointers survived soft reset");
  a_evict_length: assert property ($rose(cache_evict) |-> cache_evict [*3] ##1 !cache_evict)
    else $error("eviction window not three cycles");

  c_error_stop: cover property (sched_run && mem_rd_done && !mem_rd_ok);
  c_soft_reset: cover property ($fell(port_reset));
  c_evict: cover property ($fell(cache_evict));
endmodule // uhc_cmd_ctrl_properties

bind uhc_cmd_ctrl uhc_cmd_ctrl_properties u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_rd_done, .mem_rd_ok, .sched_run,
  .async_active, .periodic_active, .async_fetch_ptr, .periodic_fetch_ptr, .xact_abort, .port_reset,
  .port_to_companion, .cache_evict);

// ---- verif/uhc_cmd_ctrl_tb.sv ----
// Self-checking bench for the command-control block and its memory partner.
// Assumes the consts header on the include path.
`timescale 1ns/1ps
`include "uhc_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module uhc_cmd_ctrl_tb;
  localparam logic [31:0] CAP = 32'h0000_00a5;  // Arbitrary capability word
  int          error_cnt = 0, checked = 0;
  reg          aclk = 1'b0, aresetn = 1'b0, hold_busy = 1'b0, fail_next = 1'b0;
  reg  [7:0]   awaddr = 8'h0, araddr = 8'h0;
  reg  [31:0]  wdata = 32'h0;
  reg  [3:0]   wstrb = 4'hf;
  reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, busy, done, ok, run, aact, pact, abrt, prst, pcomp, evict;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata, aptr, pptr;

  always #5 aclk = ~aclk;

  uhc_cmd_ctrl #(.CAP_WORD(CAP)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xact_busy(busy),
    .mem_rd_done(done), .mem_rd_ok(ok), .sched_run(run), .async_active(aact), .periodic_active(pact),
    .async_fetch_ptr(aptr), .periodic_fetch_ptr(pptr), .xact_abort(abrt), .port_reset(prst),
    .port_to_companion(pcomp), .cache_evict(evict));
  uhc_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .sched_run(run), .hold_busy(hold_busy),
    .fail_next(fail_next), .xact_busy(busy), .mem_rd_done(done), .mem_rd_ok(ok));

  // ==========================================================
  // Bus tasks: ready is looked at before the edge that takes the item
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wo(input [7:0] a, input [31:0] d);
    reg ap, wp, ar_s, wr_s, bv;
    reg [1:0] r;
    begin
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; ap = 1'b1; wp = 1'b1; bv = 1'b0;
      while (ap || wp) begin
        @(negedge aclk); ar_s = awready; wr_s = wready;
        @(posedge aclk);
        if (ap && ar_s) begin awvalid <= 1'b0; ap = 1'b0; end
        if (wp && wr_s) begin wvalid <= 1'b0; wp = 1'b0; end
      end
      bready <= 1'b1;
      while (!bv) begin @(negedge aclk); bv = bvalid; r = bresp; @(posedge aclk); end
      bready <= 1'b0;
      `CHK(r, `UHC_RESP_OKAY)
    end
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg rv;
    begin
      araddr <= a; arvalid <= 1'b1; rv = 1'b0;
      while (!rv) begin @(negedge aclk); rv = arready; @(posedge aclk); end
      arvalid <= 1'b0; rready <= 1'b1; rv = 1'b0;
      while (!rv) begin @(negedge aclk); rv = rvalid; d = rdata; r = rresp; @(posedge aclk); end
      rready <= 1'b0;
    end
  endtask
  task automatic rc(input [7:0] a, input [31:0] m, input [31:0] e);
    reg [31:0] d;
    reg [1:0] r;
    begin
      rd(a, d, r);
      `CHK(r, `UHC_RESP_OKAY)
      `CHK(d & m, e)
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    reg [31:0] d;
    reg [1:0] r;
    begin
      rc(`UHC_CMD_OFF, 32'hffffffff, 32'h0);
      rc(`UHC_STS_OFF, 32'hffffffff, `UHC_STS_RESET);
      rd(8'h14, d, r);
      `CHK({r, d}, {`UHC_RESP_SLVERR, 32'h0})
      wo(`UHC_CMD_OFF, 32'h0000_000c);
      rc(`UHC_CMD_OFF, 32'h0000_000c, 32'h0);
    end
  endtask
  task automatic t_halt;
    hold_busy <= 1'b1;  // Keeps a transaction on the bus across the stop
    wo(`UHC_CMD_OFF, 32'h1);
    rc(`UHC_STS_OFF, 32'h1000, 32'h0);
    rc(`UHC_CMD_OFF, 32'h1, 32'h1);
    `CHK(run, 1'b1)
    wo(`UHC_CMD_OFF, 32'h0);
    rc(`UHC_STS_OFF, 32'h1000, 32'h0);
    hold_busy <= 1'b0;
    cyc(10);
    rc(`UHC_STS_OFF, 32'h1000, 32'h1000);
  endtask
  task automatic t_sched;
    wo(`UHC_ASYNC_PTR_OFF, 32'h1234_5670);
    wo(`UHC_PER_PTR_OFF, 32'h89ab_c000);
    wo(`UHC_CMD_OFF, 32'h31);
    cyc(12);
    #1;
    `CHK({aact, pact}, 2'b11)
    `CHK({aptr, pptr}, {32'h1234_5670, 32'h89ab_c000})
    @(posedge aclk);
    rc(`UHC_STS_OFF, 32'hc000, 32'hc000);
    wo(`UHC_CMD_OFF, 32'h71);
    cyc(10);
    rc(`UHC_STS_OFF, 32'h20, 32'h20);
    rc(`UHC_CMD_OFF, 32'h40, 32'h0);
    wo(`UHC_STS_OFF, 32'h20);
    rc(`UHC_STS_OFF, 32'h20, 32'h0);
    wo(`UHC_CMD_OFF, 32'h1);
    cyc(12);
    #1;
    `CHK({aact, pact}, 2'b00)
    @(posedge aclk);
    rc(`UHC_STS_OFF, 32'hc000, 32'h0);
    wo(`UHC_CMD_OFF, 32'h0);
    cyc(10);
  endtask
  task automatic t_err;
    wo(`UHC_CMD_OFF, 32'h1);
    fail_next <= 1'b1;
    cyc(12);
    fail_next <= 1'b0;
    rc(`UHC_CMD_OFF, 32'h1, 32'h0);
    `CHK(run, 1'b0)
    rc(`UHC_STS_OFF, 32'h1000, 32'h1000);
  endtask
  task automatic t_srst;
    wo(`UHC_CMD_OFF, 32'h2);
    #1;
    `CHK({abrt, prst, pcomp, run}, 4'b1110)
    @(posedge aclk);
    rc(`UHC_CMD_OFF, 32'h2, 32'h2);
    wo(`UHC_CMD_OFF, 32'h0);
    rc(`UHC_CMD_OFF, 32'h2, 32'h2);
    cyc(20);
    rc(`UHC_CMD_OFF, 32'hffffffff, 32'h0);
    rc(`UHC_ASYNC_PTR_OFF, 32'hffffffff, 32'h0);
    rc(`UHC_STS_OFF, 32'hffffffff, `UHC_STS_RESET);
    rc(`UHC_ENG_OFF, 32'hffffffff, CAP);
  endtask

  task automatic results;
    $display("errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(1);
    t_reset;
    t_halt;
    t_sched;
    t_err;
    t_srst;
    results;
  end
  initial begin
    #100000;
    error_cnt++;
    results;
  end
endmodule // uhc_cmd_ctrl_tb
